// file: rtl/ctm_pkg.sv
// constants and types shared by the compact timer
package ctm_pkg;
  // register indices on the byte port
  localparam logic [2:0] CTM_ADDR_CTRL0 = 3'h0;
  localparam logic [2:0] CTM_ADDR_CTRL1 = 3'h1;
  localparam logic [2:0] CTM_ADDR_CNT_LO = 3'h2;
  localparam logic [2:0] CTM_ADDR_CNT_HI = 3'h3;
  localparam logic [2:0] CTM_ADDR_CMPA_LO = 3'h4;
  localparam logic [2:0] CTM_ADDR_CMPA_HI = 3'h5;
  // timer_control_0 fields
  localparam int CTM_C0_PAUSE = 7;
  localparam int CTM_C0_CKSEL_LSB = 4;
  localparam int CTM_C0_ENABLE = 3;
  localparam int CTM_C0_PERIOD_LSB = 0;
  // timer_control_1 fields
  localparam int CTM_C1_MODE_LSB = 6;
  localparam int CTM_C1_PINFN_LSB = 4;
  localparam int CTM_C1_OUTCTL = 3;
  localparam int CTM_C1_POL = 2;
  localparam int CTM_C1_DUTYPER = 1;
  localparam int CTM_C1_CLRSEL = 0;
  // reset values
  localparam logic [7:0] CTM_CTRL0_RST = 8'h00;
  localparam logic [7:0] CTM_CTRL1_RST = 8'h00;
  localparam logic [9:0] CTM_CMPA_RST = 10'h000;
  // clock select codes
  localparam logic [2:0] CTM_CK_SYS_DIV4 = 3'h0;
  localparam logic [2:0] CTM_CK_SYS = 3'h1;
  localparam logic [2:0] CTM_CK_HIGH_DIV16 = 3'h2;
  localparam logic [2:0] CTM_CK_HIGH_DIV64 = 3'h3;
  localparam logic [2:0] CTM_CK_SUB_A = 3'h4;
  localparam logic [2:0] CTM_CK_SUB_B = 3'h5;
  localparam logic [2:0] CTM_CK_EXT_RISE = 3'h6;
  localparam logic [2:0] CTM_CK_EXT_FALL = 3'h7;
  // prescaler terminal counts
  localparam logic [1:0] CTM_SYS_DIV4_LAST = 2'h3;
  localparam logic [5:0] CTM_HIGH_DIV16_LAST = 6'h0f;
  localparam logic [5:0] CTM_HIGH_DIV64_LAST = 6'h3f;
  // counter extremes
  localparam logic [9:0] CTM_CNT_MAX = 10'h3ff;
  localparam logic [9:0] CTM_CNT_ZERO = 10'h000;
  // pin function codes
  localparam logic [1:0] CTM_FN_NONE = 2'h0;
  localparam logic [1:0] CTM_FN_LOW = 2'h1;
  localparam logic [1:0] CTM_FN_HIGH = 2'h2;
  localparam logic [1:0] CTM_FN_TOGGLE = 2'h3;
  typedef enum logic [1:0] {
    CTM_MODE_COMPARE,
    CTM_MODE_UNDEF,
    CTM_MODE_PWM,
    CTM_MODE_TIMER
  } ctm_mode_e;
endpackage

// file: rtl/ctm_timer.sv
// compact timer: 10-bit counter, two comparators, byte register port
// Overview of operation
// - ten-bit up counter advances on each active edge of the timer clock
// - period comparator checks three bits against counter bits nine to seven
// - compare-A checks a ten-bit value against the whole counter
// - software cannot load counter; enable rising edge clears it to zero
// - overflow or selected compare match clears counter and raises an event
// - separate event outputs for compare-A match and period match
// - three-bit field picks system, high, subsidiary or external clock
// - external clock counts on rising or falling edge as selected
// - compare mode drives output high, low or toggles on compare-A match
// - inverted output is always the inverse of the timer output
// - pwm mode makes an edge-aligned waveform on both output pins
// - one comparator sets pwm duty, the other its period
// - modes are compare output, timer/counter and pwm
// - low bytes go through one shared buffer, moved on high access
// - compare-A low write fills buffer; high write loads both bytes
// - high read returns high byte and copies low byte into buffer
// - counter pair is read-only; compare-A pair is read-write
// - clock select codes: sys/4, sys, high/16, high/64, sub, ext edges
// - period value n matches at n*128 clocks; zero means 1024
// - clear select picks compare-A or period/overflow; unused in pwm
// - pause freezes counter; release resumes from the held value
`timescale 1ns/10ps
`default_nettype none
module ctm_timer (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic high_clock,
  input wire logic subsidiary_clock,
  input wire logic ext_clock_input,
  output logic timer_output,
  output logic timer_output_inverted,
  output logic int_compare_a,
  output logic int_period
);
  logic [7:0] ctrl0;
  logic [7:0] ctrl1;
  logic [9:0] cmpa;
  logic [9:0] cnt;
  logic [7:0] buffer;
  logic [1:0] sys_div;
  logic [5:0] high_div;
  logic high_q;
  logic sub_q;
  logic ext_q;
  logic cmp_level;

  // field decode
  wire logic pause = ctrl0[ctm_pkg::CTM_C0_PAUSE];
  wire logic enable = ctrl0[ctm_pkg::CTM_C0_ENABLE];
  wire logic [2:0] clock_select =
    ctrl0[ctm_pkg::CTM_C0_CKSEL_LSB +: 3];
  wire logic [2:0] period_field =
    ctrl0[ctm_pkg::CTM_C0_PERIOD_LSB +: 3];
  wire ctm_pkg::ctm_mode_e mode =
    ctm_pkg::ctm_mode_e'(ctrl1[ctm_pkg::CTM_C1_MODE_LSB +: 2]);
  wire logic [1:0] pin_fn = ctrl1[ctm_pkg::CTM_C1_PINFN_LSB +: 2];
  wire logic out_ctl = ctrl1[ctm_pkg::CTM_C1_OUTCTL];
  wire logic polarity = ctrl1[ctm_pkg::CTM_C1_POL];
  wire logic duty_per = ctrl1[ctm_pkg::CTM_C1_DUTYPER];
  wire logic clear_select = ctrl1[ctm_pkg::CTM_C1_CLRSEL];
  wire logic is_pwm = (mode == ctm_pkg::CTM_MODE_PWM);
  wire logic is_cmp = (mode == ctm_pkg::CTM_MODE_COMPARE);
  wire logic is_timer = (mode == ctm_pkg::CTM_MODE_TIMER);

  // register port decode
  wire logic wr_ctrl0 = wr && (addr == ctm_pkg::CTM_ADDR_CTRL0);
  wire logic wr_ctrl1 = wr && (addr == ctm_pkg::CTM_ADDR_CTRL1);
  wire logic wr_a_lo = wr && (addr == ctm_pkg::CTM_ADDR_CMPA_LO);
  wire logic wr_a_hi = wr && (addr == ctm_pkg::CTM_ADDR_CMPA_HI);
  wire logic rd_cnt_hi = rd && (addr == ctm_pkg::CTM_ADDR_CNT_HI);
  wire logic rd_a_hi = rd && (addr == ctm_pkg::CTM_ADDR_CMPA_HI);
  wire logic rd_lo = rd && ((addr == ctm_pkg::CTM_ADDR_CNT_LO) ||
                            (addr == ctm_pkg::CTM_ADDR_CMPA_LO));
  wire logic enable_rise =
    wr_ctrl0 && wdata[ctm_pkg::CTM_C0_ENABLE] && !enable;

  // clock sources; pins arrive synchronous, so plain edge detection
  wire logic high_rise = high_clock && !high_q;
  wire logic sub_rise = subsidiary_clock && !sub_q;
  wire logic ext_rise = ext_clock_input && !ext_q;
  wire logic ext_fall = !ext_clock_input && ext_q;
  wire logic tick_sys4 = (sys_div == ctm_pkg::CTM_SYS_DIV4_LAST);
  wire logic tick_h16 = high_rise &&
    (high_div[3:0] == ctm_pkg::CTM_HIGH_DIV16_LAST[3:0]);
  wire logic tick_h64 = high_rise &&
    (high_div == ctm_pkg::CTM_HIGH_DIV64_LAST);
  logic tick;
  always_comb begin
    unique case (clock_select)
      ctm_pkg::CTM_CK_SYS_DIV4: tick = tick_sys4;
      ctm_pkg::CTM_CK_SYS: tick = 1'b1;
      ctm_pkg::CTM_CK_HIGH_DIV16: tick = tick_h16;
      ctm_pkg::CTM_CK_HIGH_DIV64: tick = tick_h64;
      ctm_pkg::CTM_CK_SUB_A: tick = sub_rise;
      ctm_pkg::CTM_CK_SUB_B: tick = sub_rise;
      ctm_pkg::CTM_CK_EXT_RISE: tick = ext_rise;
      ctm_pkg::CTM_CK_EXT_FALL: tick = ext_fall;
    endcase
  end

  // counting and comparison
  wire logic count_en = enable && !pause && tick;
  wire logic [10:0] cnt_inc = {1'b0, cnt} + 11'h001;
  wire logic overflow = count_en && (cnt == ctm_pkg::CTM_CNT_MAX);
  // period match lands on the first count of the matching 128 block
  wire logic p_hit = (cnt_inc[9:7] == period_field) &&
                     (cnt_inc[6:0] == 7'h00);
  wire logic p_match = count_en &&
    ((period_field == 3'h0) ? overflow : p_hit);
  wire logic a_match = count_en && (cnt_inc[9:0] == cmpa);
  // pwm always clears on its period comparator, clear select ignored
  wire logic clr_a = is_pwm ? duty_per : clear_select;
  wire logic cnt_clear = clr_a ? a_match : p_match;
  wire logic [9:0] next_cnt = cnt_clear ? ctm_pkg::CTM_CNT_ZERO :
                              cnt_inc[9:0];

  // pwm duty from the comparator not setting the period
  wire logic [9:0] duty = duty_per ? {period_field, 7'h00} : cmpa;
  wire logic pwm_on = (cnt < duty);
  logic pwm_level;
  always_comb begin
    unique case (pin_fn)
      2'h0: pwm_level = !out_ctl;
      2'h1: pwm_level = out_ctl;
      2'h2: pwm_level = pwm_on ? out_ctl : !out_ctl;
      2'h3: pwm_level = !out_ctl;
    endcase
  end
  // timer/counter mode leaves the pin undefined; low is chosen
  wire logic pin_level = is_timer ? 1'b0 :
    ((is_pwm ? pwm_level : cmp_level) ^ polarity);

  logic next_cmp_level;
  always_comb begin
    next_cmp_level = cmp_level;
    if (enable_rise) begin
      next_cmp_level = out_ctl;
    end else if (is_cmp && a_match) begin
      unique case (pin_fn)
        ctm_pkg::CTM_FN_NONE: next_cmp_level = cmp_level;
        ctm_pkg::CTM_FN_LOW: next_cmp_level = 1'b0;
        ctm_pkg::CTM_FN_HIGH: next_cmp_level = 1'b1;
        ctm_pkg::CTM_FN_TOGGLE: next_cmp_level = !cmp_level;
      endcase
    end
  end

  // read mux: high bytes direct, low bytes from the shared buffer
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    unique case (addr)
      ctm_pkg::CTM_ADDR_CTRL0: next_rdata = ctrl0;
      ctm_pkg::CTM_ADDR_CTRL1: next_rdata = ctrl1;
      ctm_pkg::CTM_ADDR_CNT_LO: next_rdata = buffer;
      ctm_pkg::CTM_ADDR_CNT_HI: next_rdata = {6'h00, cnt[9:8]};
      ctm_pkg::CTM_ADDR_CMPA_LO: next_rdata = buffer;
      ctm_pkg::CTM_ADDR_CMPA_HI: next_rdata = {6'h00, cmpa[9:8]};
      default: next_rdata = 8'h00;
    endcase
  end

  // buffer transfer; out-of-order access gives stale data by design
  logic [7:0] next_buffer;
  always_comb begin
    next_buffer = buffer;
    if (wr_a_lo) begin
      next_buffer = wdata;
    end else if (rd_cnt_hi) begin
      next_buffer = cnt[7:0];
    end else if (rd_a_hi) begin
      next_buffer = cmpa[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl0 <= ctm_pkg::CTM_CTRL0_RST;
      ctrl1 <= ctm_pkg::CTM_CTRL1_RST;
      cmpa <= ctm_pkg::CTM_CMPA_RST;
      buffer <= 8'h00;
      rdata <= 8'h00;
    end else begin
      // counter pair has no write path
      if (wr_ctrl0) ctrl0 <= wdata;
      if (wr_ctrl1) ctrl1 <= wdata;
      if (wr_a_hi) cmpa <= {wdata[1:0], buffer};
      buffer <= next_buffer;
      rdata <= rd ? next_rdata : 8'h00;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= ctm_pkg::CTM_CNT_ZERO;
    end else if (enable_rise) begin
      cnt <= ctm_pkg::CTM_CNT_ZERO;
    end else if (count_en) begin
      cnt <= next_cnt;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sys_div <= 2'h0;
      high_div <= 6'h00;
      high_q <= 1'b0;
      sub_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      sys_div <= sys_div + 2'h1;
      if (high_rise) high_div <= high_div + 6'h01;
      high_q <= high_clock;
      sub_q <= subsidiary_clock;
      ext_q <= ext_clock_input;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cmp_level <= 1'b0;
      timer_output <= 1'b0;
      timer_output_inverted <= 1'b1;
      int_compare_a <= 1'b0;
      int_period <= 1'b0;
    end else begin
      cmp_level <= next_cmp_level;
      timer_output <= pin_level;
      timer_output_inverted <= !pin_level;
      int_compare_a <= a_match;
      int_period <= p_match;
    end
  end

  property p_enable_clear;
    @(posedge sys_clk) disable iff (!rstn)
      enable_rise |=> (cnt == 10'h000);
  endproperty
  a_enable_clear: assert property (p_enable_clear)
    else $error("counter not cleared by enable rise");

  property p_count_up;
    @(posedge sys_clk) disable iff (!rstn)
      (count_en && !cnt_clear && !enable_rise && cnt != 10'h3ff) |=>
        (cnt == 10'($past(cnt) + 10'h001));
  endproperty
  a_count_up: assert property (p_count_up)
    else $error("counter did not advance by one");

  property p_wrap;
    @(posedge sys_clk) disable iff (!rstn)
      (overflow && !enable_rise) |=> (cnt == 10'h000);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter did not wrap after 1023");

  property p_pause_hold;
    @(posedge sys_clk) disable iff (!rstn)
      (pause && !enable_rise) |=> $stable(cnt);
  endproperty
  a_pause_hold: assert property (p_pause_hold)
    else $error("counter moved while paused");

  property p_inverse;
    @(posedge sys_clk) disable iff (!rstn)
      timer_output_inverted == !timer_output;
  endproperty
  a_inverse: assert property (p_inverse)
    else $error("inverted output not inverse");

  property p_period_event;
    @(posedge sys_clk) disable iff (!rstn)
      (p_match && period_field != 3'h0 && !enable_rise) |=>
        (int_period && cnt[6:0] == 7'h00);
  endproperty
  a_period_event: assert property (p_period_event)
    else $error("period match event missing");

  property p_clear_on_a;
    @(posedge sys_clk) disable iff (!rstn)
      (a_match && clr_a && !enable_rise) |=>
        (cnt == 10'h000) && int_compare_a;
  endproperty
  a_clear_on_a: assert property (p_clear_on_a)
    else $error("compare-A match did not clear counter");

  property p_toggle;
    @(posedge sys_clk) disable iff (!rstn)
      (is_cmp && a_match && !enable_rise && pin_fn == 2'h3) |=>
        (cmp_level != $past(cmp_level));
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("compare output did not toggle");

  property p_cmpa_write;
    @(posedge sys_clk) disable iff (!rstn)
      (wr_a_lo ##2 wr_a_hi) |=>
        (cmpa == {$past(wdata[1:0]), $past(wdata, 3)});
  endproperty
  a_cmpa_write: assert property (p_cmpa_write)
    else $error("compare-A pair not loaded from buffer");

  property p_cnt_read;
    @(posedge sys_clk) disable iff (!rstn)
      rd_cnt_hi |=> (buffer == $past(cnt[7:0])) &&
        (rdata == {6'h00, $past(cnt[9:8])});
  endproperty
  a_cnt_read: assert property (p_cnt_read)
    else $error("counter high read wrong");

  property p_lo_read;
    @(posedge sys_clk) disable iff (!rstn)
      rd_lo |=> (rdata == $past(buffer));
  endproperty
  a_lo_read: assert property (p_lo_read)
    else $error("low byte read bypassed buffer");
endmodule
`default_nettype wire

// file: verif/ctm_far_side.sv
// far-side model: internal clock sources and external event pin
`timescale 1ns/10ps
`default_nettype none
module ctm_far_side (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ext_kick,
  input wire logic slow,
  output logic high_clock,
  output logic subsidiary_clock,
  output logic ext_clock_input
);
  logic [1:0] sub_cnt;
  logic [2:0] hold;
  // high clock rises every 2nd cycle, sub clock every 6th
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      high_clock <= 1'b0;
      subsidiary_clock <= 1'b0;
      sub_cnt <= 2'h0;
    end else begin
      high_clock <= ~high_clock;
      sub_cnt <= (sub_cnt == 2'h2) ? 2'h0 : sub_cnt + 2'h1;
      if (sub_cnt == 2'h2) begin
        subsidiary_clock <= ~subsidiary_clock;
      end
    end
  end
  // one event per kick; slow kicks hold the pin high longer
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ext_clock_input <= 1'b0;
      hold <= 3'h0;
    end else if (ext_kick) begin
      ext_clock_input <= 1'b1;
      hold <= slow ? 3'h5 : 3'h1;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end else begin
      ext_clock_input <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench for the compact timer
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
  errors++; $display("wrong value %s: expected %0h, seen %0h", nm, ex, \
  got); end end
module testbench;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ext_kick = 1'b0;
  logic slow = 1'b0;
  logic [7:0] rdata;
  logic high_clock, subsidiary_clock, ext_clock_input;
  logic timer_output, timer_output_inverted, int_compare_a, int_period;
  int errors = 0;
  int n_tests = 0;
  int n_a = 0;
  int n_p = 0;
  int n, n2, e, hi_cnt;
  bit in_win;
  logic [7:0] v;
  logic [9:0] k, m;
  always #50 sys_clk = ~sys_clk;
  ctm_timer i_ctm_timer (.sys_clk(sys_clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .high_clock(high_clock), .subsidiary_clock(subsidiary_clock),
    .ext_clock_input(ext_clock_input), .timer_output(timer_output),
    .timer_output_inverted(timer_output_inverted),
    .int_compare_a(int_compare_a), .int_period(int_period));
  ctm_far_side i_ctm_far_side (.sys_clk(sys_clk), .rstn(rstn),
    .ext_kick(ext_kick), .slow(slow), .high_clock(high_clock),
    .subsidiary_clock(subsidiary_clock),
    .ext_clock_input(ext_clock_input));
  // events are one-cycle pulses, so a per-edge count is exact
  always @(posedge sys_clk) begin
    if (int_compare_a === 1'b1) n_a++;
    if (int_period === 1'b1) n_p++;
  end
  always @(negedge sys_clk) begin
    if (rstn) `CHK("inv pin", ~timer_output, timer_output_inverted)
  end
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    d = rdata;
  endtask
  // high byte first, or the low byte comes from a stale buffer
  task automatic rd_pair(input logic [2:0] lo, output logic [9:0] val);
    logic [7:0] h;
    logic [7:0] l;
    rd_reg(lo + 3'h1, h);
    rd_reg(lo, l);
    val = {h[1:0], l};
  endtask
  task automatic set_cmpa(input logic [9:0] val);
    wr_reg(ctm_pkg::CTM_ADDR_CMPA_LO, val[7:0]);
    wr_reg(ctm_pkg::CTM_ADDR_CMPA_HI, {6'h00, val[9:8]});
  endtask
  // enable drops first so the final write is a clean rising edge
  task automatic cfg(input logic [7:0] c1, input logic [7:0] c0);
    wr_reg(ctm_pkg::CTM_ADDR_CTRL0, 8'h00);
    wr_reg(ctm_pkg::CTM_ADDR_CTRL1, c1);
    wr_reg(ctm_pkg::CTM_ADDR_CTRL0, c0);
  endtask
  task automatic steps(input int cnt);
    repeat (cnt) begin
      @(posedge sys_clk);
      ext_kick <= 1'b1;
      slow <= 1'($urandom);
      @(posedge sys_clk);
      ext_kick <= 1'b0;
      repeat (9) @(posedge sys_clk);
    end
  endtask
  function automatic int exp_ticks(input int code, input int w);
    case (code)
      0: return w / 4;
      1: return w;
      2: return w / 32;
      3: return w / 128;
      default: return w / 6;
    endcase
  endfunction
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    v = 8'($urandom(70889));
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    rd_reg(ctm_pkg::CTM_ADDR_CTRL1, v);
    `CHK("ctrl1", ctm_pkg::CTM_CTRL1_RST, v)
    rd_pair(ctm_pkg::CTM_ADDR_CMPA_LO, k);
    `CHK("compare-a reset", ctm_pkg::CTM_CMPA_RST, k)
    wr_reg(ctm_pkg::CTM_ADDR_CNT_HI, 8'h03);
    wr_reg(ctm_pkg::CTM_ADDR_CNT_LO, 8'h55);
    rd_pair(ctm_pkg::CTM_ADDR_CNT_LO, k);
    `CHK("counter", 10'h000, k)
    wr_reg(3'h6, 8'h5a);
    rd_reg(3'h6, v);
    `CHK("unmapped", 8'h00, v)
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      k = (i == 0) ? 10'h3ff : 10'($urandom);
      set_cmpa(k);
      wr_reg(ctm_pkg::CTM_ADDR_CMPA_LO, ~k[7:0]);
      rd_pair(ctm_pkg::CTM_ADDR_CMPA_LO, m);
      `CHK("compare-a", k, m)
    end
    $display("test compare-a access done");
    for (int c = 6; c < 8; c++) begin
      n = 1 + int'($urandom % 20);
      n2 = 1 + int'($urandom % 20);
      cfg(8'hc0, {1'b0, 3'(c), 4'h8});
      steps(n);
      wr_reg(ctm_pkg::CTM_ADDR_CTRL0, {1'b1, 3'(c), 4'h8});
      steps(5);
      wr_reg(ctm_pkg::CTM_ADDR_CTRL0, {1'b0, 3'(c), 4'h8});
      steps(n2);
      rd_pair(ctm_pkg::CTM_ADDR_CNT_LO, k);
      `CHK("event count", 10'(n + n2), k)
      cfg(8'hc0, {1'b0, 3'(c), 4'h8});
      rd_pair(ctm_pkg::CTM_ADDR_CNT_LO, k);
      `CHK("cleared count", 10'h000, k)
    end
    $display("test external clock done");
    for (int c = 0; c < 6; c++) begin
      cfg(8'hc0, {1'b0, 3'(c), 4'h8});
      repeat (512) @(posedge sys_clk);
      wr_reg(ctm_pkg::CTM_ADDR_CTRL0, {1'b1, 3'(c), 4'h8});
      rd_pair(ctm_pkg::CTM_ADDR_CNT_LO, k);
      e = exp_ticks(c, 514);
      in_win = (int'(k) + 3 >= e && int'(k) <= e + 3);
      `CHK("clock rate", 1'b1, in_win)
    end
    $display("test clock select done");
    n = 3 + int'($urandom % 38);
    for (int f = 1; f < 4; f++) begin
      set_cmpa(10'(n));
      cfg({2'b00, 2'(f), (f == 1), 3'b001}, 8'h68);
      n_a = 0;
      n_p = 0;
      steps(1);
      `CHK("initial level", (f == 1), timer_output)
      steps(n - 1);
      `CHK("compare-a events", 1, n_a)
      `CHK("period events", 0, n_p)
      `CHK("matched level", (f != 1), timer_output)
      rd_pair(ctm_pkg::CTM_ADDR_CNT_LO, k);
      `CHK("cleared on match", 10'h000, k)
    end
    $display("test compare output done");
    for (int p = 1; p >= 0; p--) begin
      cfg(8'h00, {5'h0d, 3'(p)});
      n_p = 0;
      steps((p == 0) ? 1023 : 127);
      `CHK("early period event", 0, n_p)
      steps(1);
      `CHK("period event", 1, n_p)
      rd_pair(ctm_pkg::CTM_ADDR_CNT_LO, k);
      `CHK("period clear", 10'h000, k)
    end
    $display("test period done");
    for (int i = 0; i < 3; i++) begin
      set_cmpa((i == 2) ? 10'h100 : 10'h020);
      cfg({4'ha, 1'b1, (i == 1), (i == 2), 1'b1}, 8'h19);
      repeat (8) @(posedge sys_clk);
      hi_cnt = 0;
      repeat (512) @(negedge sys_clk) hi_cnt += int'(timer_output);
      e = (i == 0) ? 128 : ((i == 1) ? 384 : 256);
      in_win = (hi_cnt + 4 >= e && hi_cnt <= e + 4);
      `CHK("pwm high time", 1'b1, in_win)
      @(posedge sys_clk);
    end
    $display("test pwm done");
    stop_test();
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    errors++;
    stop_test();
  end
endmodule
`default_nettype wire
